/* File: hdl/rail_control_regs.v */
// Register bank for the card supply rail and panel power switch.
`timescale 1ns/1ps
`include "rail_regs_defines.vh"

module rail_control_regs (
  core_clk,
  nrst,
  reg_wr_en,
  reg_rd_en,
  reg_addr,
  reg_wdata,
  reg_rdata,
  reg_addr_hit,
  standby_exit_pin,
  card_uv_raw,
  card_oc_raw,
  card_rail_state,
  card_rail_exit_state,
  card_rail_voltage_sel,
  card_rail_enable,
  card_rail_low_power,
  card_rail_ldo_mode,
  card_rail_switch_mode,
  card_rail_fault,
  panel_switch_state,
  panel_switch_exit_state,
  panel_switch_enable,
  panel_switch_low_power
);
  parameter AW = 9;  // Register address width.

  input  wire          core_clk;                 // 20 MHz device clock.
  input  wire          nrst;                     // Asynchronous reset, active low.
  input  wire          reg_wr_en;                // Write strobe from the SPI front end.
  input  wire          reg_rd_en;                // Read strobe from the SPI front end.
  input  wire [AW-1:0] reg_addr;                 // Register address.
  input  wire [7:0]    reg_wdata;                // Write data.
  output reg  [7:0]    reg_rdata;                // Read data, registered.
  output wire          reg_addr_hit;             // Address maps to this bank.
  input  wire          standby_exit_pin;         // Standby-exit request level.
  input  wire          card_uv_raw;              // Card rail under-voltage comparator.
  input  wire          card_oc_raw;              // Card rail over-current comparator.
  output wire [2:0]    card_rail_state;          // Card rail state field.
  output wire [2:0]    card_rail_exit_state;     // Card rail exit state field.
  output wire [1:0]    card_rail_voltage_sel;    // Card rail voltage select field.
  output reg           card_rail_enable;         // Card rail on.
  output reg           card_rail_low_power;      // Card rail in low-power operation.
  output reg           card_rail_ldo_mode;       // Card rail running as regulator.
  output reg           card_rail_switch_mode;    // Card rail running as switch.
  output reg           card_rail_fault;          // Qualified card rail fault.
  output wire [2:0]    panel_switch_state;       // Panel switch state field.
  output wire [2:0]    panel_switch_exit_state;  // Panel switch exit state field.
  output reg           panel_switch_enable;      // Panel switch on.
  output reg           panel_switch_low_power;   // Panel switch low-power.

  // ---------------------------------------------------------------
  // Register storage and decode.
  // ---------------------------------------------------------------
  reg  [7:0] mask_r;      // Write mask register.
  reg  [1:0] vsel_r;      // Card rail voltage select, bits 7:6.
  reg  [1:0] vsel_nxt;    // Next voltage select.
  reg        exit_d_r;    // Delayed exit pin for edge detection.
  wire       exit_pulse;  // Rising edge of the exit pin.
  wire       hit_mask;    // Mask register addressed.
  wire       hit_sdio;    // Card rail register addressed.
  wire       hit_panel;   // Panel register addressed.
  wire [7:0] sdio_value;  // Assembled card register.
  wire [7:0] panel_value; // Assembled panel register.

  // Reset images held at full width, so that each field is taken by a
  // part-select rather than by silent truncation of a shifted constant.
  localparam [7:0] SDIO_RST  = `RST_SDIO_RAIL_CONTROL;     // Card register reset image.
  localparam [7:0] PANEL_RST = `RST_PANEL_SWITCH_CONTROL;  // Panel register reset image.

  assign hit_mask     = (reg_addr == `ADDR_SUPPLY_WRITE_MASK);
  assign hit_sdio     = (reg_addr == `ADDR_SDIO_RAIL_CONTROL);
  assign hit_panel    = (reg_addr == `ADDR_PANEL_SWITCH_CONTROL);
  assign reg_addr_hit = hit_mask | hit_sdio | hit_panel;

  // The exit pin is a level; only its rising edge copies fields, so a
  // held pin cannot undo later SPI writes to the state field.
  assign exit_pulse = standby_exit_pin & ~exit_d_r;

  // ---------------------------------------------------------------
  // Mask register and exit edge register.
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_r   <= `RST_SUPPLY_WRITE_MASK;
      exit_d_r <= 1'b0;
    end else begin
      exit_d_r <= standby_exit_pin;
      if (reg_wr_en && hit_mask) begin
        mask_r <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // Card rail: state and exit fields in a slice, voltage here.
  // ---------------------------------------------------------------
  rail_state_slice #(
    .RESET_VALUE (SDIO_RST[`EXIT_MSB:`STATE_LSB])
  ) u_card_slice (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .wr_en      (reg_wr_en & hit_sdio),
    .wr_data    (reg_wdata[5:0]),
    .wr_mask    (mask_r[5:0]),
    .exit_pulse (exit_pulse),
    .state_out  (card_rail_state),
    .exit_out   (card_rail_exit_state)
  );

  // Voltage select under the same mask.
  always @* begin
    vsel_nxt = vsel_r;
    if (reg_wr_en && hit_sdio) begin
      vsel_nxt = (vsel_r & mask_r[`VSEL_MSB:`VSEL_LSB]) |
                 (reg_wdata[`VSEL_MSB:`VSEL_LSB] & ~mask_r[`VSEL_MSB:`VSEL_LSB]);
    end
  end

  // Voltage select storage, reset to 3.3 V.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      vsel_r <= SDIO_RST[`VSEL_MSB:`VSEL_LSB];
    end else begin
      vsel_r <= vsel_nxt;
    end
  end

  assign card_rail_voltage_sel = vsel_r;
  assign sdio_value = {vsel_r, card_rail_exit_state, card_rail_state};

  // ---------------------------------------------------------------
  // Panel switch: bits 7:6 reserved, not stored.
  // ---------------------------------------------------------------
  rail_state_slice #(
    .RESET_VALUE (PANEL_RST[`EXIT_MSB:`STATE_LSB])
  ) u_panel_slice (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .wr_en      (reg_wr_en & hit_panel),
    .wr_data    (reg_wdata[5:0]),
    .wr_mask    (mask_r[5:0]),
    .exit_pulse (exit_pulse),
    .state_out  (panel_switch_state),
    .exit_out   (panel_switch_exit_state)
  );

  assign panel_value = {2'b00, panel_switch_exit_state, panel_switch_state};

  // ---------------------------------------------------------------
  // Read path: registered data; unmapped addresses read zero.
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      if (hit_mask) begin
        reg_rdata <= mask_r;
      end else if (hit_sdio) begin
        reg_rdata <= sdio_value;
      end else if (hit_panel) begin
        reg_rdata <= panel_value & `PANEL_WRITABLE;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Rail controls decoded from fields, registered. Reserved state
  // codes 0 to 3 hold the rail off, the safe reading.
  // ---------------------------------------------------------------
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      card_rail_enable       <= 1'b0;
      card_rail_low_power    <= 1'b0;
      card_rail_ldo_mode     <= 1'b0;
      card_rail_switch_mode  <= 1'b0;
      card_rail_fault        <= 1'b0;
      panel_switch_enable    <= 1'b0;
      panel_switch_low_power <= 1'b0;
    end else begin
      card_rail_enable       <= card_rail_state[2] & (card_rail_state != `STATE_OFF);
      card_rail_low_power    <= (card_rail_state == `STATE_LOW_POWER);
      // Reserved voltage codes select neither mode.
      card_rail_ldo_mode     <= (vsel_r == `VSEL_1V8);
      card_rail_switch_mode  <= (vsel_r == `VSEL_3V3);
      // Faults only count while regulating; a switch has no monitor.
      card_rail_fault        <= (vsel_r == `VSEL_1V8) &
                                card_rail_state[2] & (card_rail_state != `STATE_OFF) &
                                (card_uv_raw | card_oc_raw);
      panel_switch_enable    <= panel_switch_state[2] &
                                (panel_switch_state != `STATE_OFF);
      panel_switch_low_power <= (panel_switch_state == `STATE_LOW_POWER);
    end
  end

endmodule // rail_control_regs

/* File: hdl/rail_regs_defines.vh */
// Constants for the rail control register bank.
`ifndef RAIL_REGS_DEFINES_VH
`define RAIL_REGS_DEFINES_VH

// ---------------------------------------------------------------
// Register offsets.
// ---------------------------------------------------------------
`define ADDR_SUPPLY_WRITE_MASK    9'h034
`define ADDR_SDIO_RAIL_CONTROL    9'h04d
`define ADDR_PANEL_SWITCH_CONTROL 9'h04f

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define RST_SUPPLY_WRITE_MASK     8'h00
`define RST_SDIO_RAIL_CONTROL     8'h64
`define RST_PANEL_SWITCH_CONTROL  8'h24

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define STATE_LSB                 0
`define STATE_MSB                 2
`define EXIT_LSB                  3
`define EXIT_MSB                  5
`define VSEL_LSB                  6
`define VSEL_MSB                  7

// ---------------------------------------------------------------
// Field codes.
// ---------------------------------------------------------------
`define STATE_OFF                 3'h4
`define STATE_LOW_POWER           3'h5
`define VSEL_1V8                  2'h0
`define VSEL_3V3                  2'h1

// Writable bits of the panel register; bits 7:6 are reserved.
`define PANEL_WRITABLE            8'h3f

`endif

/* File: hdl/rail_state_slice.v */
// One rail's state and standby-exit fields with masked write and exit copy.
`timescale 1ns/1ps

module rail_state_slice (
  core_clk,
  nrst,
  wr_en,
  wr_data,
  wr_mask,
  exit_pulse,
  state_out,
  exit_out
);
  input  wire       core_clk;    // Device clock.
  input  wire       nrst;        // Asynchronous reset, active low.
  input  wire       wr_en;       // Write strobe for this register.
  input  wire [5:0] wr_data;     // Written bits 5:0.
  input  wire [5:0] wr_mask;     // Mask bits 5:0; a one keeps the old bit.
  input  wire       exit_pulse;  // One-cycle standby-exit event.
  output wire [2:0] state_out;   // Present rail state field.
  output wire [2:0] exit_out;    // Stored standby-exit state field.

  parameter [5:0] RESET_VALUE = 6'h24;  // Reset value of bits 5:0.

  reg  [5:0] bits_r;    // Field storage.
  reg  [5:0] bits_nxt;  // Next value.

  assign state_out = bits_r[`STATE_MSB:`STATE_LSB];
  assign exit_out  = bits_r[`EXIT_MSB:`EXIT_LSB];

  // ---------------------------------------------------------------
  // Next value: a write goes first; an exit event then copies the
  // exit field into the state field, so an exit in the same cycle
  // as a write sees the freshly written exit code.
  // ---------------------------------------------------------------
  always @* begin
    bits_nxt = bits_r;
    if (wr_en) begin
      bits_nxt = (bits_r & wr_mask) | (wr_data & ~wr_mask);
    end
    // Only codes with the top bit set (4 to 7) are copied.
    if (exit_pulse && bits_nxt[`EXIT_MSB]) begin
      bits_nxt[`STATE_MSB:`STATE_LSB] = bits_nxt[`EXIT_MSB:`EXIT_LSB];
    end
  end

  // Storage with asynchronous reset to a constant.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bits_r <= RESET_VALUE;
    end else begin
      bits_r <= bits_nxt;
    end
  end

endmodule // rail_state_slice

/* File: verif/rail_regs_props.sv */
// Concurrent checks for the rail control register bank.
`timescale 1ns/1ps
module rail_regs_props #(parameter AW = 9) (
  input wire          core_clk,
  input wire          nrst,
  input wire          reg_wr_en,
  input wire          reg_rd_en,
  input wire [AW-1:0] reg_addr,
  input wire [7:0]    reg_wdata,
  input wire [7:0]    reg_rdata,
  input wire          reg_addr_hit,
  input wire          standby_exit_pin,
  input wire          card_uv_raw,
  input wire          card_oc_raw,
  input wire [2:0]    card_rail_state,
  input wire [2:0]    card_rail_exit_state,
  input wire [1:0]    card_rail_voltage_sel,
  input wire          card_rail_ldo_mode,
  input wire          card_rail_switch_mode,
  input wire          card_rail_fault,
  input wire [2:0]    panel_switch_state,
  input wire [2:0]    panel_switch_exit_state
);
  reg  [7:0] mask_sh;                                  // Mask as seen on the bus.
  wire       card_wr = reg_wr_en && reg_addr == 9'h04d; // Write to the card register.
  // The shadow lets the checks predict masked writes without seeing inside.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mask_sh <= 8'h00;
    end else if (reg_wr_en && reg_addr == 9'h034) begin
      mask_sh <= reg_wdata;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_state_wr;
    card_wr && !$rose(standby_exit_pin) |=> card_rail_state ==
      (($past(card_rail_state) & mask_sh[2:0]) | ($past(reg_wdata[2:0]) & ~mask_sh[2:0]));
  endproperty
  property p_vsel_wr;
    card_wr |=> card_rail_voltage_sel == (($past(card_rail_voltage_sel) & mask_sh[7:6])
      | ($past(reg_wdata[7:6]) & ~mask_sh[7:6]));
  endproperty
  property p_ldo;
    $past(nrst) |-> card_rail_ldo_mode == ($past(card_rail_voltage_sel) == 2'h0);
  endproperty
  property p_switch;
    $past(nrst) |-> card_rail_switch_mode == ($past(card_rail_voltage_sel) == 2'h1);
  endproperty
  property p_fault_ldo;
    card_rail_fault |-> $past(card_rail_voltage_sel) == 2'h0;
  endproperty
  property p_fault_set;
    card_rail_voltage_sel == 2'h0 && card_rail_state[2:1] == 2'b11
      && (card_uv_raw || card_oc_raw) |=> card_rail_fault;
  endproperty
  property p_exit_copy;
    $rose(standby_exit_pin) && !reg_wr_en && card_rail_exit_state[2]
      |=> card_rail_state == $past(card_rail_exit_state);
  endproperty
  property p_exit_keep;
    $rose(standby_exit_pin) && !reg_wr_en && !panel_switch_exit_state[2]
      |=> $stable(panel_switch_state);
  endproperty
  property p_hit;
    reg_addr_hit == (reg_addr == 9'h034 || reg_addr == 9'h04d || reg_addr == 9'h04f);
  endproperty
  property p_unmapped;
    reg_rd_en && !reg_addr_hit |=> reg_rdata == 8'h00;
  endproperty
  a_state_wr: assert property (p_state_wr) else $error("masked state write wrong");
  a_vsel_wr: assert property (p_vsel_wr) else $error("masked voltage write wrong");
  a_ldo: assert property (p_ldo) else $error("regulator mode wrong");
  a_switch: assert property (p_switch) else $error("switch mode wrong");
  a_fault_ldo: assert property (p_fault_ldo) else $error("fault outside LDO mode");
  a_fault_set: assert property (p_fault_set) else $error("LDO fault missed");
  a_exit_copy: assert property (p_exit_copy) else $error("exit copy missed");
  a_exit_keep: assert property (p_exit_keep) else $error("exit copied a no-copy code");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_hit: assert property (p_hit) else $error("address decode wrong");
  c_masked: cover property (card_wr && mask_sh != 8'h00);
  c_exit: cover property ($rose(standby_exit_pin));
  c_fault: cover property (card_rail_fault);
endmodule // rail_regs_props
bind rail_control_regs rail_regs_props #(.AW(AW)) u_props (.core_clk, .nrst, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_addr_hit, .standby_exit_pin,
  .card_uv_raw, .card_oc_raw, .card_rail_state, .card_rail_exit_state,
  .card_rail_voltage_sel, .card_rail_ldo_mode, .card_rail_switch_mode, .card_rail_fault,
  .panel_switch_state, .panel_switch_exit_state);

/* File: verif/spi_host_model.sv */
// Register-side model of the system controller issuing single-byte accesses.
`timescale 1ns/1ps
module spi_host_model (
  input  wire       core_clk,
  output reg        reg_wr_en,
  output reg        reg_rd_en,
  output reg  [8:0] reg_addr,
  output reg  [7:0] reg_wdata
);
  initial begin
    {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = 19'h0_0000;
  end
  // Idle address and data show the inverse so stale values never look valid.
  task acc(input wr, input [8:0] a, input [7:0] d);
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = {a, d, wr, !wr};
    @(negedge core_clk);
    {reg_addr, reg_wdata, reg_wr_en, reg_rd_en} = {~a, ~d, 2'b00};
  endtask
endmodule // spi_host_model

/* File: verif/tb_top.sv */
// Self-checking bench for the rail control register bank.
`timescale 1ns/1ps
`include "rail_regs_defines.vh"
module tb_top;
  reg         core_clk = 1'b0;  // 20 MHz clock.
  reg         nrst     = 1'b0;  // Reset, active low.
  reg         exit_pin = 1'b0;  // Standby-exit level.
  reg         uv = 1'b0, oc = 1'b0; // Fault comparators.
  wire        wr, rd, hit, en, lp, ldo, sw, flt, pen, plp;
  wire [8:0]  addr;
  wire [7:0]  wd, rdat;
  wire [2:0]  cs, ce, ps, pe;
  wire [1:0]  vs;
  integer     n_mismatch = 0, checks_done = 0, i, mask_m, card_m, panel_m;
  reg  [31:0] lfsr = 32'h0000_6d95; // Fixed seed for repeatable runs.
  always #25 core_clk = ~core_clk;
  // Next value of the stimulus shift register.
  function [31:0] lfsr_next(input [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  spi_host_model u_host (.core_clk(core_clk), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wd));
  rail_control_regs DUT (.core_clk(core_clk), .nrst(nrst), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat), .reg_addr_hit(hit),
    .standby_exit_pin(exit_pin), .card_uv_raw(uv), .card_oc_raw(oc), .card_rail_state(cs),
    .card_rail_exit_state(ce), .card_rail_voltage_sel(vs), .card_rail_enable(en),
    .card_rail_low_power(lp), .card_rail_ldo_mode(ldo), .card_rail_switch_mode(sw),
    .card_rail_fault(flt), .panel_switch_state(ps), .panel_switch_exit_state(pe),
    .panel_switch_enable(pen), .panel_switch_low_power(plp));
  task summarize;
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Writes update the integer model with the masked-write equation.
  task wr_m(input [8:0] a, input [7:0] d);
    u_host.acc(1'b1, a, d);
    if (a == `ADDR_SUPPLY_WRITE_MASK) mask_m = d;
    if (a == `ADDR_SDIO_RAIL_CONTROL) card_m = (card_m & mask_m) | (d & ~mask_m & 255);
    if (a == `ADDR_PANEL_SWITCH_CONTROL) panel_m = ((panel_m & mask_m) | (d & ~mask_m)) & 63;
  endtask
  task rd_chk(input [8:0] a);
    u_host.acc(1'b0, a, 8'h00);
    chk(rdat, a == `ADDR_SUPPLY_WRITE_MASK ? mask_m : a == `ADDR_SDIO_RAIL_CONTROL ? card_m
      : a == `ADDR_PANEL_SWITCH_CONTROL ? panel_m : 0);
  endtask
  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch = n_mismatch + 1;
    summarize;
  end
  initial begin
    {mask_m, card_m, panel_m} = {32'd0, 32'h64, 32'h24};
    repeat (12) @(negedge core_clk);
    nrst = 1'b1;
    rd_chk(`ADDR_SDIO_RAIL_CONTROL);
    rd_chk(`ADDR_PANEL_SWITCH_CONTROL);
    chk(sw, 1);
    // Every state code, with the decodes one cycle after the field.
    for (i = 0; i < 8; i = i + 1) begin
      wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h20 | i);
      @(negedge core_clk);
      chk(cs, i);
      chk(en, i >= 5);
      chk(lp, i == 5);
    end
    // Card bring-up: 3.3 V active, off, select 1.8 V, back on.
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h46);
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h44);
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h04);
    uv = 1'b1;
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h06);
    repeat (2) @(negedge core_clk);
    chk({ldo, flt}, 2'b11);
    chk(vs, `VSEL_1V8);
    {uv, oc} = 2'b01;
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h46);
    repeat (2) @(negedge core_clk);
    chk({sw, flt}, 2'b10);
    chk(vs, `VSEL_3V3);
    oc = 1'b0;
    // Random masks and data against the model.
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      wr_m(`ADDR_SUPPLY_WRITE_MASK, lfsr[7:0]);
      wr_m(lfsr[16] ? `ADDR_SDIO_RAIL_CONTROL : `ADDR_PANEL_SWITCH_CONTROL, lfsr[15:8]);
      rd_chk(`ADDR_SUPPLY_WRITE_MASK);
      rd_chk(`ADDR_SDIO_RAIL_CONTROL);
      rd_chk(`ADDR_PANEL_SWITCH_CONTROL);
    end
    wr_m(`ADDR_SUPPLY_WRITE_MASK, 8'h00);
    wr_m(9'h035, 8'hff);
    rd_chk(9'h035);
    // Program exit fields, then raise the exit pin: card copies, panel does not.
    wr_m(`ADDR_SDIO_RAIL_CONTROL, 8'h74);
    wr_m(`ADDR_PANEL_SWITCH_CONTROL, 8'h15);
    chk({ce, pe}, 8'h32);
    exit_pin = 1'b1;
    @(negedge core_clk);
    card_m = (card_m & 248) | ((card_m >> 3) & 7);
    rd_chk(`ADDR_SDIO_RAIL_CONTROL);
    rd_chk(`ADDR_PANEL_SWITCH_CONTROL);
    chk({en, lp}, 2'b10);
    chk({pen, plp}, 2'b11);
    exit_pin = 1'b0;
    summarize;
  end
endmodule // tb_top
